// ==== hdl/cdcfg_pkg.sv ====
/*
 constants for the counter configuration decoder: switch positions,
 setting encodings and timing counts at the 20 MHz system clock.
 assumes nothing beyond a SystemVerilog compiler.
*/
package cdcfg_pkg;
    localparam int CLK_HZ = 20000000;
    // switch bit positions (position n sits at bit n-1)
    localparam int SW_ENABLE = 0;
    localparam int SW_SPEED = 1;
    localparam int SW_DIR = 2;
    localparam int SW_OMODE_LO = 3;
    localparam int SW_OMODE_HI = 4;
    localparam int SW_PULSE = 5;
    localparam int SW_RSTW = 6;
    localparam int SW_POL = 7;
    localparam logic [7:0] SW_FACTORY = 8'h00;
    // speed codes: 0 slow filtered, 1 fast, 2 tachometer fast
    localparam logic [1:0] SPEED_30HZ = 2'h0;
    localparam logic [1:0] SPEED_5KHZ = 2'h1;
    localparam logic [1:0] SPEED_10KHZ = 2'h2;
    // input mode codes; other variants come from keys only
    localparam logic [2:0] IMODE_UP = 3'h0;
    localparam logic [2:0] IMODE_DOWN = 3'h1;
    // basic output modes selectable by switch
    localparam logic [3:0] OMODE_N = 4'h0;
    localparam logic [3:0] OMODE_F = 4'h1;
    localparam logic [3:0] OMODE_C = 4'h2;
    localparam logic [3:0] OMODE_K1 = 4'h3;
    // counting function codes
    localparam logic [2:0] FUNC_PRESET1 = 3'h0;
    localparam logic [2:0] FUNC_PRESET2 = 3'h1;
    localparam logic [2:0] FUNC_TACHO = 3'h5;
    // display selection codes
    localparam logic [1:0] DISP_PV = 2'h0;
    localparam logic [1:0] DISP_TOTAL = 2'h1;
    localparam logic [1:0] DISP_BATCH = 2'h2;
    // times in their own units
    localparam int PULSE_LONG_MS = 500;
    localparam int PULSE_SHORT_MS = 50;
    localparam int RSTW_LONG_MS = 20;
    localparam int RSTW_SHORT_MS = 1;
    // pulse time held in 10 ms units, as the key settings use
    localparam logic [13:0] PULSE_LONG_CS = 14'(PULSE_LONG_MS / 10);
    localparam logic [13:0] PULSE_SHORT_CS = 14'(PULSE_SHORT_MS / 10);
    // least reset widths in cycles (ms times the whole kHz rate, no rounding up)
    localparam int RSTW_LONG_CYC = (RSTW_LONG_MS * (CLK_HZ / 1000));
    localparam int RSTW_SHORT_CYC = (RSTW_SHORT_MS * (CLK_HZ / 1000));
    localparam int RSTW_CNT_W = 20;
endpackage

// ==== hdl/cdcfg_if.sv ====
/*
 interface carrying the decoded basic settings between the decoder
 top and the reset width filter. assumes one clock domain.
*/
`timescale 1ns/1ps
interface cdcfg_if;
    logic [19:0] min_width;
    logic active_high;
    logic raw_in;
    logic ignore;
    logic accepted;
    modport top (output min_width, active_high, raw_in, ignore,
        input accepted);
    modport filt (input min_width, active_high, raw_in, ignore,
        output accepted);
endinterface

// ==== hdl/cdcfg_rfilt.sv ====
/*
 reset input width filter: accepts a reset only after it has stood
 active for the configured least width. assumes synchronous inputs.
*/
`timescale 1ns/1ps
module cdcfg_rfilt
    import cdcfg_pkg::*;
(
    // clocking
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // settings and pin
    cdcfg_if.filt cfg
);
    logic [RSTW_CNT_W-1:0] cnt_q;
    logic acc_q;
    wire logic act;
    wire logic done;

    // polarity applied here so the same filter serves both senses
    assign act = (cfg.raw_in == cfg.active_high) && !cfg.ignore;
    assign done = (cnt_q >= cfg.min_width - 20'h00001);
    assign cfg.accepted = acc_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            acc_q <= 1'b0;
        end else if (clk_en) begin
            if (!act) begin
                cnt_q <= '0;
                acc_q <= 1'b0;
            end else if (done) begin
                acc_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 20'h00001;
            end
        end
    end

    // one edge back only: a width of one accepts after a single active edge
    width_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(acc_q) |-> $past(act))
        else $error("reset accepted without standing active");
endmodule

// ==== hdl/cdcfg_top.sv ====
/*
 counter configuration decoder: samples the eight-position switch once
 after power-up, picks switch or key-entered basic settings, filters the
 reset inputs and drives the front-panel lamps.
 assumes synchronous pins, a key-settings store outside that holds its
 values across power cycles, and a display selector outside.
*/
`timescale 1ns/1ps
module cdcfg_top
    import cdcfg_pkg::*;
#(
    parameter bit TWO_STAGE = 1'b0,
    parameter int RSTW_LONG = RSTW_LONG_CYC,
    parameter int RSTW_SHORT = RSTW_SHORT_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clk_en,
    // configuration switch, bit n-1 is position n
    input wire logic [7:0] dip_sw,
    // stored key-entered settings
    input wire logic key_valid,
    input wire logic [1:0] key_speed,
    input wire logic [2:0] key_imode,
    input wire logic [3:0] key_omode,
    input wire logic [13:0] key_pulse1,
    input wire logic [13:0] key_pulse2,
    input wire logic key_rstw_short,
    input wire logic key_pol_source,
    input wire logic [1:0] key_avg,
    input wire logic [2:0] key_func,
    input wire logic key_setting_mode,
    // raw pins
    input wire logic count_input_a,
    input wire logic count_input_b,
    input wire logic reset_primary_in,
    input wire logic reset_secondary_in,
    input wire logic key_lock_n_in,
    input wire logic reset_key,
    input wire logic [1:0] disp_sel,
    // applied settings
    output logic [1:0] speed_sel,
    output logic [2:0] input_mode,
    output logic [3:0] output_mode,
    output logic [13:0] pulse1_time,
    output logic [13:0] pulse2_time,
    output logic [19:0] reset_width_cyc,
    output logic pol_source,
    output logic [1:0] avg_sel,
    output logic [2:0] func_sel,
    output logic cfg_from_switch,
    output logic cfg_valid,
    // conditioned inputs
    output logic count_a_active,
    output logic count_b_active,
    output logic reset_primary_ok,
    output logic reset_secondary_ok,
    output logic key_locked,
    output logic counter_clear,
    // lamps
    output logic lamp_reset,
    output logic lamp_total,
    output logic lamp_batch
);
    // widths beyond the filter counter would never be reached
    if (RSTW_LONG < 1 || RSTW_SHORT < 1 ||
        RSTW_LONG >= (1 << RSTW_CNT_W) ||
        RSTW_SHORT >= (1 << RSTW_CNT_W)) begin : g_bad_width
        $error("reset width counts out of range");
    end

    logic rs1_q, rs2_q;
    wire logic rst_n;
    assign rst_n = rs2_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end

    // switch capture: once after release, held until next power-up
    logic [7:0] sw_q;
    logic taken_q;
    logic run_prev_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_q <= SW_FACTORY;
            taken_q <= 1'b0;
        end else if (clk_en && !taken_q) begin
            sw_q <= dip_sw;
            taken_q <= 1'b1;
        end
    end

    wire logic sw_en = sw_q[SW_ENABLE] && taken_q;
    wire logic is_tacho = (key_func == FUNC_TACHO);
    wire logic [2:0] dflt_func = TWO_STAGE ? FUNC_PRESET2 : FUNC_PRESET1;

    // switch-derived values
    wire logic [1:0] sw_speed_slow = SPEED_30HZ;
    wire logic [1:0] sw_speed_fast = is_tacho ? SPEED_10KHZ : SPEED_5KHZ;
    wire logic [1:0] sw_speed = sw_q[SW_SPEED] ? sw_speed_fast
                                              : sw_speed_slow;
    wire logic [2:0] sw_imode = sw_q[SW_DIR] ? IMODE_DOWN
                                             : IMODE_UP;
    wire logic [3:0] sw_omode = {2'b00, sw_q[SW_OMODE_HI],
                                 sw_q[SW_OMODE_LO]};
    wire logic [13:0] sw_pulse = sw_q[SW_PULSE] ? PULSE_SHORT_CS
                                                : PULSE_LONG_CS;
    wire logic sw_rstw_short = sw_q[SW_RSTW];
    wire logic sw_pol = sw_q[SW_POL];

    // selection between switch and stored key values
    wire logic [1:0] sel_speed = sw_en ? sw_speed : key_speed;
    wire logic [2:0] sel_imode = sw_en ? sw_imode : key_imode;
    wire logic [3:0] sel_omode = sw_en ? sw_omode : key_omode;
    wire logic [13:0] sel_pulse1 = sw_en ? sw_pulse : key_pulse1;
    wire logic sel_rstw = sw_en ? sw_rstw_short : key_rstw_short;
    wire logic sel_pol = sw_en ? sw_pol : key_pol_source;
    wire logic [2:0] sel_func = key_valid ? key_func : dflt_func;
    wire logic [19:0] sel_width = sel_rstw ? 20'(RSTW_SHORT)
                                           : 20'(RSTW_LONG);

    // key edits land only when setting mode is left
    wire logic run_entry = run_prev_q && !key_setting_mode;
    wire logic load = !cfg_valid || run_entry;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            speed_sel <= SPEED_30HZ;
            input_mode <= IMODE_UP;
            output_mode <= OMODE_N;
            pulse1_time <= PULSE_LONG_CS;
            pulse2_time <= PULSE_LONG_CS;
            reset_width_cyc <= 20'(RSTW_LONG);
            pol_source <= 1'b0;
            avg_sel <= 2'h0;
            func_sel <= FUNC_PRESET1;
            cfg_from_switch <= 1'b0;
            cfg_valid <= 1'b0;
            run_prev_q <= 1'b0;
            counter_clear <= 1'b0;
        end else if (clk_en) begin
            run_prev_q <= key_setting_mode;
            counter_clear <= run_entry;
            if (taken_q && load) begin
                speed_sel <= sel_speed;
                input_mode <= sel_imode;
                output_mode <= sel_omode;
                pulse1_time <= sel_pulse1;
                pulse2_time <= key_pulse2;
                reset_width_cyc <= sel_width;
                pol_source <= sel_pol;
                avg_sel <= key_avg;
                func_sel <= sel_func;
                cfg_from_switch <= sw_en;
                cfg_valid <= 1'b1;
            end
        end
    end

    // reset filters, one per reset input
    wire logic tacho_on = (func_sel == FUNC_TACHO);
    cdcfg_if c1 ();
    cdcfg_if c2 ();
    assign c1.min_width = reset_width_cyc;
    assign c1.active_high = pol_source;
    assign c1.raw_in = reset_primary_in;
    assign c1.ignore = !cfg_valid;
    assign c2.min_width = reset_width_cyc;
    assign c2.active_high = pol_source;
    assign c2.raw_in = reset_secondary_in;
    assign c2.ignore = !cfg_valid || tacho_on;

    cdcfg_rfilt u_rf1 (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .cfg(c1.filt));
    cdcfg_rfilt u_rf2 (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .cfg(c2.filt));

    // sink sensing pulls low when active; source drives high
    wire logic a_act = (count_input_a == pol_source);
    wire logic b_act = (count_input_b == pol_source) && !tacho_on;
    wire logic prim_raw = (reset_primary_in == pol_source);
    wire logic lamp_sel_t = (disp_sel == DISP_TOTAL);
    wire logic lamp_sel_b = (disp_sel == DISP_BATCH);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_a_active <= 1'b0;
            count_b_active <= 1'b0;
            reset_primary_ok <= 1'b0;
            reset_secondary_ok <= 1'b0;
            key_locked <= 1'b0;
            lamp_reset <= 1'b0;
            lamp_total <= 1'b0;
            lamp_batch <= 1'b0;
        end else if (clk_en) begin
            count_a_active <= a_act && cfg_valid;
            count_b_active <= b_act && cfg_valid;
            reset_primary_ok <= c1.accepted;
            reset_secondary_ok <= c2.accepted;
            key_locked <= !key_lock_n_in;
            lamp_reset <= (prim_raw && cfg_valid) || reset_key;
            lamp_total <= lamp_sel_t;
            lamp_batch <= lamp_sel_b;
        end
    end

    // guards; loaded values are checked on the next edge after an enabled load edge
    sw_frozen_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        taken_q && $past(taken_q) |-> $stable(sw_q))
        else $error("switch copy changed after capture");
    sw_factory_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !taken_q |-> sw_q == SW_FACTORY)
        else $error("switch copy not factory before capture");
    sw_ignored_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cfg_valid && !cfg_from_switch && $past(clk_en)
        && $past(run_entry) |-> speed_sel == $past(key_speed))
        else $error("switch used while disabled");
    speed_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load && sw_en)
        |-> speed_sel == (!$past(sw_q[SW_SPEED]) ? SPEED_30HZ
            : $past(is_tacho) ? SPEED_10KHZ : SPEED_5KHZ))
        else $error("speed does not follow switch");
    down_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load && sw_en)
        |-> input_mode == ($past(sw_q[SW_DIR]) ? IMODE_DOWN
                                               : IMODE_UP))
        else $error("direction does not follow switch");
    omode_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load && sw_en)
        |-> output_mode == (!$past(sw_q[SW_OMODE_HI])
            ? ($past(sw_q[SW_OMODE_LO]) ? OMODE_F : OMODE_N)
            : ($past(sw_q[SW_OMODE_LO]) ? OMODE_K1 : OMODE_C)))
        else $error("output mode does not follow switch");
    pulse_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load && sw_en)
        |-> pulse1_time == ($past(sw_q[SW_PULSE]) ? PULSE_SHORT_CS
                                                  : PULSE_LONG_CS))
        else $error("pulse time wrong");
    width_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load)
        |-> reset_width_cyc == ($past(sel_rstw) ? 20'(RSTW_SHORT)
                                                : 20'(RSTW_LONG)))
        else $error("reset width wrong");
    pol_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load && sw_en)
        |-> pol_source == $past(sw_q[SW_POL]))
        else $error("polarity does not follow switch");
    key_only_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load)
        |-> pulse2_time == $past(key_pulse2))
        else $error("second pulse time not from keys");
    default_fn_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $past(clk_en) && $past(taken_q && load && !key_valid)
        |-> func_sel == (TWO_STAGE ? FUNC_PRESET2 : FUNC_PRESET1))
        else $error("default function wrong");
    run_clear_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        counter_clear && $past(clk_en) |-> !$past(key_setting_mode))
        else $error("counter cleared while still in setting mode");
    lamp_rst_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && reset_key |=> lamp_reset)
        else $error("reset lamp dark with key pressed");
    lamp_tot_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en |=> lamp_total == ($past(disp_sel) == DISP_TOTAL))
        else $error("total lamp mismatch");
    lamp_bat_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en |=> lamp_batch == ($past(disp_sel) == DISP_BATCH))
        else $error("batch lamp mismatch");
    tacho_b_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && tacho_on |=> !count_b_active)
        else $error("second count input used in tachometer");
    lock_pol_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en |=> key_locked == !$past(key_lock_n_in))
        else $error("key lock polarity wrong");
endmodule

// ==== bench/cdcfg_panel.sv ====
/*
 operator panel model: the switch and the stored key settings as the
 operator leaves them. assumes the bench changes them between edges.
*/
`timescale 1ns/1ps
module cdcfg_panel (
    // requests from the bench
    input wire logic mclk,
    input wire logic [7:0] sw_req,
    input wire logic [44:0] key_req,
    // panel levels
    output logic [7:0] dip_sw,
    output logic [44:0] keys
);
    // levers move between clocks, so the device never sees half a change
    always_ff @(posedge mclk) begin
        dip_sw <= sw_req;
        keys <= key_req;
    end
endmodule

// ==== bench/testbench.sv ====
/*
 self-checking bench for the configuration decoder.
 assumes the panel model and the design files are compiled first.
*/
`timescale 1ns/1ps
module testbench
    import cdcfg_pkg::*;
;
    typedef struct {int due; int id; logic [31:0] v;} cdcfg_note_s;
    localparam int RL = 20;
    localparam int RS = 4;
    cdcfg_note_s q[$];
    cdcfg_note_s nt;
    int cyc = 0, n_mismatch = 0, n_compared = 0, k, m;
    int seed = 32'h749b;
    logic mclk = 0, nrst = 0, clk_en = 1, ksm = 0;
    logic ca = 1, cb = 1, rp = 1, rs = 1, kl = 1, rk = 0;
    logic [1:0] ds = 2'h0;
    logic [7:0] swr = 8'h00, sw;
    logic [44:0] kr = '0, kv, kw;
    logic [3:0] omt [4] = '{OMODE_N, OMODE_F, OMODE_C, OMODE_K1};
    wire [7:0] dip;
    wire [44:0] ks;
    wire [1:0] o_sp, o_avg;
    wire [2:0] o_im, o_fn;
    wire [3:0] o_om;
    wire [13:0] o_p1, o_p2;
    wire [19:0] o_rw;
    wire o_pol, o_fs, o_cv, o_ca, o_cb, o_rpo, o_rso;
    wire o_kl, o_cc, o_lr, o_lt, o_lb;

    cdcfg_panel i_panel (.mclk(mclk), .sw_req(swr), .key_req(kr),
        .dip_sw(dip), .keys(ks));
    cdcfg_top #(.TWO_STAGE(1'b0), .RSTW_LONG(RL), .RSTW_SHORT(RS)) i_dut (
        .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .dip_sw(dip),
        .key_valid(ks[44]), .key_speed(ks[43:42]), .key_imode(ks[41:39]),
        .key_omode(ks[38:35]), .key_pulse1(ks[34:21]),
        .key_pulse2(ks[20:7]), .key_rstw_short(ks[6]),
        .key_pol_source(ks[5]), .key_avg(ks[4:3]), .key_func(ks[2:0]),
        .key_setting_mode(ksm), .count_input_a(ca), .count_input_b(cb),
        .reset_primary_in(rp), .reset_secondary_in(rs),
        .key_lock_n_in(kl), .reset_key(rk), .disp_sel(ds),
        .speed_sel(o_sp), .input_mode(o_im), .output_mode(o_om),
        .pulse1_time(o_p1), .pulse2_time(o_p2), .reset_width_cyc(o_rw),
        .pol_source(o_pol), .avg_sel(o_avg), .func_sel(o_fn),
        .cfg_from_switch(o_fs), .cfg_valid(o_cv), .count_a_active(o_ca),
        .count_b_active(o_cb), .reset_primary_ok(o_rpo),
        .reset_secondary_ok(o_rso), .key_locked(o_kl), .counter_clear(o_cc),
        .lamp_reset(o_lr), .lamp_total(o_lt), .lamp_batch(o_lb));

    always #25 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    function automatic logic [31:0] outv(int id);
        case (id)
            0: return 32'(o_sp);
            1: return 32'(o_im);
            2: return 32'(o_om);
            3: return 32'(o_p1);
            4: return 32'(o_p2);
            5: return 32'(o_rw);
            6: return 32'(o_pol);
            7: return 32'(o_avg);
            8: return 32'(o_fn);
            9: return 32'(o_fs);
            10: return 32'(o_lr);
            11: return 32'(o_lt);
            12: return 32'(o_lb);
            13: return 32'(o_kl);
            14: return 32'(o_cb);
            15: return 32'(o_rso);
            16: return 32'(o_rpo);
            default: return 32'(o_ca);
        endcase
    endfunction

    task automatic check(logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
        end
    endtask

    task automatic note(int id, logic [31:0] v, int d);
        q.push_back('{cyc + d, id, v});
    endtask

    // outputs stand until the next reload, so a late look is still fair
    always @(negedge mclk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            nt = q.pop_front();
            check(outv(nt.id), nt.v);
        end
    end

    task automatic mk(logic [2:0] f, output logic [44:0] o);
        logic [31:0] a, b;
        a = $random(seed);
        b = $random(seed);
        o = {1'b1, 1'b0, a[0], 1'b0, a[2:1], 1'b0, a[5:3], 1'b0, a[18:6],
             1'b0, b[12:0], b[13], b[14], b[16:15], f};
    endtask

    task automatic pwr(logic [7:0] s, logic [44:0] v);
        int w;
        swr <= s;
        kr <= v;
        nrst <= 0;
        repeat (5) @(posedge mclk);
        nrst <= 1;
        w = 0;
        while (o_cv !== 1'b1 && w < 20) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 20) n_mismatch++;
    endtask

    task automatic expcfg(logic [7:0] s, logic [44:0] v);
        logic [31:0] sp, im, om, p1, rw;
        if (s[0]) begin
            sp = 32'(SPEED_5KHZ);
            if (v[2:0] == FUNC_TACHO)
                sp = 32'(SPEED_10KHZ);
            if (!s[1])
                sp = 32'(SPEED_30HZ);
            im = 32'(s[2] ? IMODE_DOWN : IMODE_UP);
            om = 32'(omt[{s[4], s[3]}]);
            p1 = 32'(s[5] ? PULSE_SHORT_CS : PULSE_LONG_CS);
            rw = s[6] ? RS : RL;
        end else begin
            sp = 32'(v[43:42]);
            im = 32'(v[41:39]);
            om = 32'(v[38:35]);
            p1 = 32'(v[34:21]);
            rw = v[6] ? RS : RL;
        end
        note(0, sp, 1);
        note(1, im, 1);
        note(2, om, 1);
        note(3, p1, 1);
        note(5, rw, 1);
        note(6, 32'(s[0] ? s[7] : v[5]), 1);
        note(4, 32'(v[20:7]), 1);
        note(7, 32'(v[4:3]), 1);
        note(8, 32'(v[2:0]), 1);
        note(9, 32'(s[0]), 1);
        repeat (2) @(posedge mclk);
    endtask

    task automatic lamps(logic p);
        int i;
        {ca, cb, rp, rs, kl, rk} <= {~p, ~p, ~p, ~p, 1'b1, 1'b0};
        repeat (3) @(posedge mclk);
        for (i = 0; i < 3; i++) begin
            ds <= 2'(i);
            note(11, 32'(i == 1), 2);
            note(12, 32'(i == 2), 2);
            repeat (3) @(posedge mclk);
        end
        rk <= 1;
        note(10, 1, 2);
        repeat (3) @(posedge mclk);
        {rk, rp, kl, ca} <= {1'b0, p, 1'b0, p};
        note(10, 1, 2);
        note(13, 1, 2);
        note(17, 1, 2);
        repeat (3) @(posedge mclk);
        {rp, kl, ca} <= {~p, 1'b1, ~p};
        note(10, 0, 2);
        note(13, 0, 2);
        repeat (3) @(posedge mclk);
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        test_done;
    end

    initial begin
        @(posedge mclk);
        mk(FUNC_PRESET1, kv);
        pwr(SW_FACTORY, kv);
        expcfg(SW_FACTORY, kv);
        $display("test factory done");
        for (m = 0; m < 4; m++) begin
            sw = 8'($random(seed)) | 8'h01;
            sw[4:3] = m[1:0];
            mk(FUNC_PRESET1, kv);
            pwr(sw, kv);
            expcfg(sw, kv);
            swr <= ~sw;
            repeat (4) @(posedge mclk);
            expcfg(sw, kv);
        end
        $display("test switch done");
        pwr(8'hfe, kv);
        expcfg(8'hfe, kv);
        lamps(kv[5]);
        $display("test lamps done");
        mk(FUNC_PRESET2, kw);
        kr <= kw;
        ksm <= 1;
        repeat (3) @(posedge mclk);
        ksm <= 0;
        k = 0;
        repeat (6) begin
            @(negedge mclk);
            k += int'(o_cc === 1'b1);
        end
        check(32'(k), 1);
        @(posedge mclk);
        expcfg(8'hfe, kw);
        $display("test reload done");
        // with the enable low the lamp copy must not follow the selector
        clk_en <= 0;
        ds <= 2'h1;
        repeat (3) @(posedge mclk);
        note(11, 0, 1);
        clk_en <= 1;
        note(11, 1, 2);
        repeat (3) @(posedge mclk);
        $display("test freeze done");
        mk(FUNC_TACHO, kv);
        kv[6] = 1'b1;
        kv[5] = 1'b0;
        pwr(8'h43, kv);
        expcfg(8'h43, kv);
        lamps(1'b0);
        cb <= 0;
        note(14, 0, 2);
        rp <= 0;
        rs <= 0;
        repeat (10) @(posedge mclk);
        note(16, 1, 1);
        note(15, 0, 1);
        rp <= 1;
        rs <= 1;
        repeat (5) @(posedge mclk);
        note(16, 0, 1);
        repeat (2) @(posedge mclk);
        $display("test tacho done");
        mk(FUNC_PRESET2, kv);
        kv[44] = 1'b0;
        kv[6] = 1'b1;
        pwr(SW_FACTORY, kv);
        note(8, 32'(FUNC_PRESET1), 1);
        rs <= kv[5];
        repeat (10) @(posedge mclk);
        note(15, 1, 1);
        rs <= ~kv[5];
        repeat (3) @(posedge mclk);
        $display("test default done");
        test_done;
    end
endmodule
